// ### core/rxc_channel.sv
// receive channel: oscillator mixer, resampling comb, fifth-order comb, fir, two output paths
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - stages run mixer, resampler, comb5, fir
// - oscillator tuning and accumulator are 32 bits
// - real input times cosine and sine
// - carrier moved to zero before decimation
// - phase and amplitude dither enable separately
// - programmable phase offset added to phase
// - resampler rate is interpolation over decimation
// - comb5 decimates by its programmed rate
// - fir uses 20-bit programmable coefficient memory
// - fir decimation programmable 1 to 256
// - fir length up to 160 taps
// - halfband joins channels, doubles the rate; here each halfband takes the one channel's I and Q only
// - gain stage spans 96.3 dB
// - two halfband and two gain instances
// - each bypassable, gain may be constant
// - fir reuses spare cycles for taps
// - each output path has its own port
module rxc_channel
	import rxc_pkg::*;
#(
	parameter int TAPS = RCF_TAPS_MAX
)
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// converter samples
	input wire logic signed [IN_W-1:0] adc_data_i,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	// output port a
	output logic signed [SMP_W-1:0] port_a_i_o,
	output logic signed [SMP_W-1:0] port_a_q_o,
	output logic port_a_vld_o,
	// output port b
	output logic signed [SMP_W-1:0] port_b_i_o,
	output logic signed [SMP_W-1:0] port_b_q_o,
	output logic port_b_vld_o
);
	// ============================================================
	// helpers
	function automatic logic signed [SMP_W-1:0] rxc_trunc(input logic signed [ACC_W-1:0] v,
		input logic [5:0] sh);
		logic signed [ACC_W-1:0] t;
		t = v >>> sh;
		return t[SMP_W-1:0];
	endfunction

	// wraps an index into the 160-entry rings
	function automatic logic [7:0] rxc_ring(input logic [8:0] v);
		logic [8:0] t;
		t = (v >= 9'(TAPS)) ? v - 9'(TAPS) : v;
		return t[7:0];
	endfunction

	function automatic logic signed [12:0] rxc_sin(input logic [5:0] p);
		logic [4:0] k;
		logic signed [12:0] m;
		k = p[4] ? 5'h10 - {1'b0, p[3:0]} : {1'b0, p[3:0]};
		m = $signed({1'b0, SIN_Q[k]});
		return p[5] ? -m : m;
	endfunction

	// ============================================================
	// registers
	logic [NCO_W-1:0] nco_freq_r;
	logic [15:0] nco_phase_r;
	logic [2:0] nco_ctrl_r;
	logic [11:0] rc2_dec_r;
	logic [8:0] rc2_int_r;
	logic [5:0] rc2_scale_r;
	logic [4:0] c5_dec_r;
	logic [5:0] c5_scale_r;
	logic [7:0] rcf_dec_r;
	logic [7:0] rcf_taps_r;
	logic [7:0] rcf_cofs_r;
	logic [3:0] out_ctrl_r;
	logic [GAIN_W-1:0] gain_a_r;
	logic [GAIN_W-1:0] gain_b_r;
	logic coef_page_r;
	logic signed [COEF_W-1:0] coef_r [TAPS];
	rxc_rcf_state_t rcf_st_r;
	logic [7:0] wp_r;
	logic [8:0] cidx;

	assign cidx = {1'b0, coef_page_r, reg_addr_i[6:0]};

	// configuration writes; unmapped writes are dropped
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			nco_freq_r <= '0;
			nco_phase_r <= '0;
			nco_ctrl_r <= '0;
			rc2_dec_r <= '0;
			rc2_int_r <= '0;
			rc2_scale_r <= '0;
			c5_dec_r <= '0;
			c5_scale_r <= '0;
			rcf_dec_r <= '0;
			rcf_taps_r <= '0;
			rcf_cofs_r <= '0;
			out_ctrl_r <= RST_OUT_CTRL;
			gain_a_r <= RST_GAIN;
			gain_b_r <= RST_GAIN;
			coef_page_r <= 1'b0;
		end
		else if (ce_i && reg_wr_i)
		begin
			if (reg_addr_i == REG_NCO_FREQ)
				nco_freq_r <= reg_wdata_i;
			else if (reg_addr_i == REG_NCO_PHASE)
				nco_phase_r <= reg_wdata_i[15:0];
			else if (reg_addr_i == REG_NCO_CTRL)
				nco_ctrl_r <= reg_wdata_i[2:0];
			else if (reg_addr_i == REG_RC2_DEC)
				rc2_dec_r <= reg_wdata_i[11:0];
			else if (reg_addr_i == REG_RC2_INT)
				rc2_int_r <= reg_wdata_i[8:0];
			else if (reg_addr_i == REG_RC2_SCALE)
				rc2_scale_r <= reg_wdata_i[5:0];
			else if (reg_addr_i == REG_C5_DEC)
				c5_dec_r <= reg_wdata_i[4:0];
			else if (reg_addr_i == REG_C5_SCALE)
				c5_scale_r <= reg_wdata_i[5:0];
			else if (reg_addr_i == REG_RCF_DEC)
				rcf_dec_r <= reg_wdata_i[7:0];
			else if (reg_addr_i == REG_RCF_TAPS)
				rcf_taps_r <= (reg_wdata_i[7:0] < 8'(TAPS)) ? reg_wdata_i[7:0] : 8'(TAPS - 1);
			else if (reg_addr_i == REG_RCF_COFS)
				rcf_cofs_r <= (reg_wdata_i[7:0] < 8'(TAPS)) ? reg_wdata_i[7:0] : 8'(TAPS - 1);
			else if (reg_addr_i == REG_OUT_CTRL)
				out_ctrl_r <= reg_wdata_i[3:0];
			else if (reg_addr_i == REG_GAIN_A)
				gain_a_r <= reg_wdata_i[GAIN_W-1:0];
			else if (reg_addr_i == REG_GAIN_B)
				gain_b_r <= reg_wdata_i[GAIN_W-1:0];
			else if (reg_addr_i == REG_COEF_PAGE)
				coef_page_r <= reg_wdata_i[0];
		end
	end

	// coefficient memory; two pages of 128 cover 160 entries
	always_ff @(posedge clock_i)
	begin
		if (ce_i && reg_wr_i && reg_addr_i <= REG_COEFFICIENT_MEMORY_LAST && cidx < 9'(TAPS))
			coef_r[cidx[7:0]] <= $signed(reg_wdata_i[COEF_W-1:0]);
	end

	// read data stand in the cycle after the strobe, zero otherwise
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			reg_rdata_o <= '0;
		else if (ce_i)
		begin
			reg_rdata_o <= '0;
			if (!reg_rd_i)
				reg_rdata_o <= '0;
			else if (reg_addr_i <= REG_COEFFICIENT_MEMORY_LAST)
				reg_rdata_o <= (cidx < 9'(TAPS)) ? DATA_W'(coef_r[cidx[7:0]]) : '0;
			else if (reg_addr_i == REG_NCO_FREQ)
				reg_rdata_o <= nco_freq_r;
			else if (reg_addr_i == REG_NCO_PHASE)
				reg_rdata_o <= DATA_W'(nco_phase_r);
			else if (reg_addr_i == REG_NCO_CTRL)
				reg_rdata_o <= DATA_W'(nco_ctrl_r);
			else if (reg_addr_i == REG_RC2_DEC)
				reg_rdata_o <= DATA_W'(rc2_dec_r);
			else if (reg_addr_i == REG_RC2_INT)
				reg_rdata_o <= DATA_W'(rc2_int_r);
			else if (reg_addr_i == REG_RC2_SCALE)
				reg_rdata_o <= DATA_W'(rc2_scale_r);
			else if (reg_addr_i == REG_C5_DEC)
				reg_rdata_o <= DATA_W'(c5_dec_r);
			else if (reg_addr_i == REG_C5_SCALE)
				reg_rdata_o <= DATA_W'(c5_scale_r);
			else if (reg_addr_i == REG_RCF_DEC)
				reg_rdata_o <= DATA_W'(rcf_dec_r);
			else if (reg_addr_i == REG_RCF_TAPS)
				reg_rdata_o <= DATA_W'(rcf_taps_r);
			else if (reg_addr_i == REG_RCF_COFS)
				reg_rdata_o <= DATA_W'(rcf_cofs_r);
			else if (reg_addr_i == REG_OUT_CTRL)
				reg_rdata_o <= DATA_W'(out_ctrl_r);
			else if (reg_addr_i == REG_GAIN_A)
				reg_rdata_o <= DATA_W'(gain_a_r);
			else if (reg_addr_i == REG_GAIN_B)
				reg_rdata_o <= DATA_W'(gain_b_r);
			else if (reg_addr_i == REG_STATUS)
				reg_rdata_o <= DATA_W'({rcf_st_r == RCF_MAC, wp_r});
			else if (reg_addr_i == REG_COEF_PAGE)
				reg_rdata_o <= DATA_W'(coef_page_r);
		end
	end

	// ============================================================
	// oscillator and mixer
	logic signed [IN_W-1:0] adc_s1_r;
	logic signed [IN_W-1:0] adc_s2_r;
	logic [NCO_W-1:0] acc_r;
	logic [15:0] lfsr_r;
	logic signed [SMP_W-1:0] mix_r [2];
	logic mix_vld_r;
	logic [NCO_W-1:0] phase;
	logic signed [12:0] cosv;
	logic signed [12:0] sinv;
	logic signed [IN_W+12:0] prod_c;
	logic signed [IN_W+12:0] prod_s;

	always_comb
	begin
		phase = acc_r + {nco_phase_r, 16'h0};
		if (nco_ctrl_r[PH_DITH_BIT])
			phase = phase + {24'h0, lfsr_r[7:0]};
		cosv = rxc_sin(phase[NCO_W-1:NCO_W-6] + 6'h10);
		sinv = rxc_sin(phase[NCO_W-1:NCO_W-6]);
		if (nco_ctrl_r[AMP_DITH_BIT])
		begin
			cosv = cosv + {12'h0, lfsr_r[9]};
			sinv = sinv + {12'h0, lfsr_r[10]};
		end
		prod_c = adc_s2_r * cosv;
		prod_s = adc_s2_r * sinv;
	end

	// the converter pins are asynchronous, two flops before use
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			adc_s1_r <= '0;
			adc_s2_r <= '0;
			acc_r <= '0;
			lfsr_r <= RST_LFSR;
		end
		else if (ce_i)
		begin
			adc_s1_r <= adc_data_i;
			adc_s2_r <= adc_s1_r;
			acc_r <= acc_r + nco_freq_r;
			lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[14] ^ lfsr_r[12] ^ lfsr_r[3]};
		end
	end

	// down-conversion to baseband; bypass passes the real input as I
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mix_r[0] <= '0;
			mix_r[1] <= '0;
			mix_vld_r <= 1'b0;
		end
		else if (ce_i)
		begin
			mix_vld_r <= 1'b1;
			if (nco_ctrl_r[NCO_BYP_BIT])
			begin
				mix_r[0] <= {adc_s2_r, 4'h0};
				mix_r[1] <= '0;
			end
			else
			begin
				mix_r[0] <= prod_c[IN_W+10:7];
				mix_r[1] <= -prod_s[IN_W+10:7];
			end
		end
	end

	// ============================================================
	// resampling second-order comb; interpolation must not exceed decimation
	logic signed [ACC_W-1:0] rc_int_r [2][2];
	logic signed [ACC_W-1:0] rc_last_r [2][2];
	logic signed [SMP_W-1:0] rc_out_r [2];
	logic rc_vld_r;
	logic [12:0] rc_ph_r;
	logic [12:0] rc_nxt;
	logic rc_emit;
	logic signed [ACC_W-1:0] rc_d1 [2];
	logic signed [ACC_W-1:0] rc_d2 [2];

	always_comb
	begin
		rc_nxt = rc_ph_r + 13'(rc2_int_r) + 13'h1;
		rc_emit = rc_nxt >= 13'(rc2_dec_r) + 13'h1;
		for (int c = 0; c < 2; c++)
		begin
			rc_d1[c] = rc_int_r[c][1] - rc_last_r[c][0];
			rc_d2[c] = rc_d1[c] - rc_last_r[c][1];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rc_ph_r <= '0;
			rc_vld_r <= 1'b0;
			for (int c = 0; c < 2; c++)
			begin
				rc_out_r[c] <= '0;
				rc_int_r[c] <= '{default: '0};
				rc_last_r[c] <= '{default: '0};
			end
		end
		else if (ce_i)
		begin
			rc_vld_r <= mix_vld_r && rc_emit;
			if (mix_vld_r)
			begin
				rc_ph_r <= rc_emit ? rc_nxt - 13'(rc2_dec_r) - 13'h1 : rc_nxt;
				for (int c = 0; c < 2; c++)
				begin
					rc_int_r[c][0] <= rc_int_r[c][0] + ACC_W'(mix_r[c]);
					rc_int_r[c][1] <= rc_int_r[c][1] + rc_int_r[c][0];
					if (rc_emit)
					begin
						rc_last_r[c][0] <= rc_int_r[c][1];
						rc_last_r[c][1] <= rc_d1[c];
						rc_out_r[c] <= rxc_trunc(rc_d2[c], rc2_scale_r);
					end
				end
			end
		end
	end

	// ============================================================
	// fifth-order comb, response set by decimation alone
	logic signed [ACC_W-1:0] c5_int_r [2][5];
	logic signed [ACC_W-1:0] c5_last_r [2][5];
	logic signed [ACC_W-1:0] c5_d [2][6];
	logic signed [SMP_W-1:0] c5_out_r [2];
	logic c5_vld_r;
	logic [4:0] c5_cnt_r;

	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			c5_d[c][0] = c5_int_r[c][4];
			for (int k = 0; k < 5; k++)
				c5_d[c][k+1] = c5_d[c][k] - c5_last_r[c][k];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			c5_cnt_r <= '0;
			c5_vld_r <= 1'b0;
			for (int c = 0; c < 2; c++)
			begin
				c5_out_r[c] <= '0;
				c5_int_r[c] <= '{default: '0};
				c5_last_r[c] <= '{default: '0};
			end
		end
		else if (ce_i)
		begin
			c5_vld_r <= rc_vld_r && (c5_cnt_r == c5_dec_r);
			if (rc_vld_r)
			begin
				c5_cnt_r <= (c5_cnt_r == c5_dec_r) ? 5'h0 : c5_cnt_r + 5'h1;
				for (int c = 0; c < 2; c++)
				begin
					c5_int_r[c][0] <= c5_int_r[c][0] + ACC_W'(rc_out_r[c]);
					for (int k = 1; k < 5; k++)
						c5_int_r[c][k] <= c5_int_r[c][k] + c5_int_r[c][k-1];
					if (c5_cnt_r == c5_dec_r)
					begin
						for (int k = 0; k < 5; k++)
							c5_last_r[c][k] <= c5_d[c][k];
						c5_out_r[c] <= rxc_trunc(c5_d[c][5], c5_scale_r);
					end
				end
			end
		end
	end

	// ============================================================
	// programmable fir: one tap per cycle, spare cycles come from decimation
	logic signed [SMP_W-1:0] dm_r [2][TAPS];
	logic [7:0] rcf_cnt_r;
	logic [7:0] base_r;
	logic [7:0] tap_r;
	logic signed [ACC_W-1:0] mac_r [2];
	logic signed [SMP_W-1:0] rcf_out_r [2];
	logic rcf_vld_r;
	logic [7:0] didx;
	logic [7:0] kidx;

	assign didx = rxc_ring(9'(base_r) + 9'(TAPS) - 9'(tap_r));
	assign kidx = rxc_ring(9'(rcf_cofs_r) + 9'(tap_r));

	// sample ring; a 160-tap filter fed mid-sum loses its oldest sample
	always_ff @(posedge clock_i)
	begin
		if (ce_i && c5_vld_r)
		begin
			dm_r[0][wp_r] <= c5_out_r[0];
			dm_r[1][wp_r] <= c5_out_r[1];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rcf_st_r <= RCF_IDLE;
			wp_r <= '0;
			rcf_cnt_r <= '0;
			base_r <= '0;
			tap_r <= '0;
			rcf_vld_r <= 1'b0;
			mac_r <= '{default: '0};
			rcf_out_r <= '{default: '0};
		end
		else if (ce_i)
		begin
			rcf_vld_r <= 1'b0;
			if (c5_vld_r)
			begin
				wp_r <= rxc_ring(9'(wp_r) + 9'h1);
				rcf_cnt_r <= (rcf_cnt_r == rcf_dec_r) ? 8'h0 : rcf_cnt_r + 8'h1;
			end
			case (rcf_st_r)
				RCF_IDLE:
				begin
					if (c5_vld_r && rcf_cnt_r == rcf_dec_r)
					begin
						rcf_st_r <= RCF_MAC;
						base_r <= wp_r;
						tap_r <= '0;
						mac_r <= '{default: '0};
					end
				end
				RCF_MAC:
				begin
					for (int c = 0; c < 2; c++)
						mac_r[c] <= mac_r[c] + ACC_W'(dm_r[c][didx] * coef_r[kidx]);
					tap_r <= tap_r + 8'h1;
					// a length lowered mid-sum ends the sum instead of wrapping the tap count
					if (tap_r >= rcf_taps_r)
					begin
						rcf_st_r <= RCF_IDLE;
						rcf_vld_r <= 1'b1;
						for (int c = 0; c < 2; c++)
							rcf_out_r[c] <= rxc_trunc(mac_r[c]
								+ ACC_W'(dm_r[c][didx] * coef_r[kidx]), RCF_SHIFT);
					end
				end
				default:
					rcf_st_r <= RCF_IDLE;
			endcase
		end
	end

	// ============================================================
	// two output paths, each with its own halfband, gain and port
	rxc_hb_gain #(.W(SMP_W)) u_path_a (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.hb_bypass_i(out_ctrl_r[HB_BYP_A_BIT]),
		.gain_bypass_i(out_ctrl_r[GAIN_BYP_A_BIT]),
		.gain_i(gain_a_r),
		.in_i_i(rcf_out_r[0]),
		.in_q_i(rcf_out_r[1]),
		.in_vld_i(rcf_vld_r),
		.out_i_o(port_a_i_o),
		.out_q_o(port_a_q_o),
		.out_vld_o(port_a_vld_o)
	);

	rxc_hb_gain #(.W(SMP_W)) u_path_b (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.hb_bypass_i(out_ctrl_r[HB_BYP_B_BIT]),
		.gain_bypass_i(out_ctrl_r[GAIN_BYP_B_BIT]),
		.gain_i(gain_b_r),
		.in_i_i(rcf_out_r[0]),
		.in_q_i(rcf_out_r[1]),
		.in_vld_i(rcf_vld_r),
		.out_i_o(port_b_i_o),
		.out_q_o(port_b_q_o),
		.out_vld_o(port_b_vld_o)
	);

	// ============================================================
	// checks
	chk_nco_accum_step: assert property (@(posedge clock_i) disable iff (rst_i)
		ce_i |=> (acc_r == $past(acc_r) + $past(nco_freq_r)))
		else $error("phase accumulator did not advance by the tuning word");
	chk_mix_zero_in: assert property (@(posedge clock_i) disable iff (rst_i)
		(ce_i && !nco_ctrl_r[NCO_BYP_BIT] && adc_s2_r == 0) |=> (mix_r[0] == 0 && mix_r[1] == 0))
		else $error("mixer produced output from a zero sample");
	chk_mix_bypass_q: assert property (@(posedge clock_i) disable iff (rst_i)
		(ce_i && nco_ctrl_r[NCO_BYP_BIT]) |=> (mix_r[1] == 0 && mix_vld_r))
		else $error("bypassed translator left quadrature nonzero");
	chk_rc2_ratio_hold: assert property (@(posedge clock_i) disable iff (rst_i)
		(ce_i && mix_vld_r && (14'(rc_ph_r) + 14'(rc2_int_r) < 14'(rc2_dec_r))) |=> !rc_vld_r)
		else $error("resampler emitted before its phase reached the decimation");
	chk_c5_decim_skip: assert property (@(posedge clock_i) disable iff (rst_i)
		(ce_i && rc_vld_r && c5_cnt_r != c5_dec_r) |=> !c5_vld_r)
		else $error("comb5 emitted off its decimation count");
	chk_stage_cascade: assert property (@(posedge clock_i) disable iff (rst_i)
		(ce_i && $past(ce_i) && c5_vld_r) |-> $past(rc_vld_r))
		else $error("comb5 output without a resampler sample");
	chk_rcf_decim_wait: assert property (@(posedge clock_i) disable iff (rst_i)
		(ce_i && rcf_st_r == RCF_IDLE && c5_vld_r && rcf_cnt_r != rcf_dec_r) |=> rcf_st_r == RCF_IDLE)
		else $error("fir started before its decimation count");
	chk_rcf_tap_end: assert property (@(posedge clock_i) disable iff (rst_i)
		(ce_i && rcf_st_r == RCF_MAC && tap_r == rcf_taps_r) |=> (rcf_vld_r && rcf_st_r == RCF_IDLE))
		else $error("fir did not finish after the programmed tap count");
endmodule
`default_nettype wire

// ### shared/rxc_pkg.sv
// constants and types shared by the receive channel datapath
package rxc_pkg;
	// ============================================================
	// widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int IN_W = 14;
	localparam int SMP_W = 18;
	localparam int COEF_W = 20;
	localparam int NCO_W = 32;
	localparam int ACC_W = 48;
	localparam int GAIN_W = 16;
	// ============================================================
	// register offsets
	localparam logic [7:0] REG_COEFFICIENT_MEMORY_LAST = 8'h7f;
	localparam logic [7:0] REG_NCO_FREQ = 8'h85;
	localparam logic [7:0] REG_NCO_PHASE = 8'h87;
	localparam logic [7:0] REG_NCO_CTRL = 8'h88;
	localparam logic [7:0] REG_RC2_DEC = 8'h90;
	localparam logic [7:0] REG_RC2_INT = 8'h91;
	localparam logic [7:0] REG_RC2_SCALE = 8'h92;
	localparam logic [7:0] REG_C5_DEC = 8'h94;
	localparam logic [7:0] REG_C5_SCALE = 8'h95;
	localparam logic [7:0] REG_RCF_DEC = 8'ha0;
	localparam logic [7:0] REG_RCF_TAPS = 8'ha2;
	localparam logic [7:0] REG_RCF_COFS = 8'ha3;
	localparam logic [7:0] REG_OUT_CTRL = 8'ha9;
	localparam logic [7:0] REG_GAIN_A = 8'hb0;
	localparam logic [7:0] REG_GAIN_B = 8'hb1;
	localparam logic [7:0] REG_STATUS = 8'hb2;
	localparam logic [7:0] REG_COEF_PAGE = 8'hb3;
	// ============================================================
	// field positions
	localparam int NCO_BYP_BIT = 0;
	localparam int PH_DITH_BIT = 1;
	localparam int AMP_DITH_BIT = 2;
	localparam int HB_BYP_A_BIT = 0;
	localparam int HB_BYP_B_BIT = 1;
	localparam int GAIN_BYP_A_BIT = 2;
	localparam int GAIN_BYP_B_BIT = 3;
	// ============================================================
	// reset values and counts
	localparam logic [15:0] RST_GAIN = 16'h8000;
	localparam logic [15:0] RST_LFSR = 16'hace1;
	localparam logic [3:0] RST_OUT_CTRL = 4'hf;
	localparam int RCF_TAPS_MAX = 160;
	localparam int GAIN_SHIFT = 15;
	localparam logic [5:0] RCF_SHIFT = 6'h13;
	// quarter wave sine, 17 points, amplitude 2047
	localparam logic [16:0][11:0] SIN_Q = {12'h7ff, 12'h7f5, 12'h7d8, 12'h7a7, 12'h763,
		12'h70d, 12'h6a6, 12'h62e, 12'h5a7, 12'h513, 12'h471, 12'h3c5, 12'h30f, 12'h252,
		12'h18f, 12'h0c9, 12'h000};
	typedef enum {RCF_IDLE, RCF_MAC} rxc_rcf_state_t;
endpackage

// ### core/rxc_hb_gain.sv
// halfband interpolate-by-two stage followed by a constant gain stage
`timescale 1ns/1ps
`default_nettype none
module rxc_hb_gain
	import rxc_pkg::*;
#(
	parameter int W = SMP_W
)
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// control
	input wire logic hb_bypass_i,
	input wire logic gain_bypass_i,
	input wire logic [GAIN_W-1:0] gain_i,
	// sample in
	input wire logic signed [W-1:0] in_i_i,
	input wire logic signed [W-1:0] in_q_i,
	input wire logic in_vld_i,
	// sample out
	output logic signed [W-1:0] out_i_o,
	output logic signed [W-1:0] out_q_o,
	output logic out_vld_o
);
	// ============================================================
	// halfband
	logic signed [W-1:0] x_r [2][3];
	logic signed [W-1:0] hb_r [2];
	logic signed [W-1:0] hold_r [2];
	logic hb_vld_r;
	logic pend_r;
	logic signed [W+5:0] odd [2];
	logic signed [W-1:0] din [2];

	// odd phase sits between the middle two of the four samples: (-x0+9x1+9x2-x3)/16
	always_comb
	begin
		din[0] = in_i_i;
		din[1] = in_q_i;
		for (int c = 0; c < 2; c++)
		begin
			odd[c] = (W+6)'(9 * ((W+6)'(x_r[c][0]) + (W+6)'(x_r[c][1])))
				- (W+6)'(din[c]) - (W+6)'(x_r[c][2]);
		end
	end

	// two outputs per input unless bypassed: interpolated point first, then the sample
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hb_vld_r <= 1'b0;
			pend_r <= 1'b0;
			for (int c = 0; c < 2; c++)
			begin
				hb_r[c] <= '0;
				hold_r[c] <= '0;
				for (int k = 0; k < 3; k++)
					x_r[c][k] <= '0;
			end
		end
		else if (ce_i)
		begin
			hb_vld_r <= 1'b0;
			pend_r <= 1'b0;
			if (in_vld_i && hb_bypass_i)
			begin
				hb_r <= din;
				hb_vld_r <= 1'b1;
			end
			else if (in_vld_i)
			begin
				for (int c = 0; c < 2; c++)
				begin
					hb_r[c] <= odd[c][W+3:4];
					hold_r[c] <= x_r[c][0];
					x_r[c][0] <= din[c];
					x_r[c][1] <= x_r[c][0];
					x_r[c][2] <= x_r[c][1];
				end
				hb_vld_r <= 1'b1;
				pend_r <= 1'b1;
			end
			else if (pend_r)
			begin
				hb_r <= hold_r;
				hb_vld_r <= 1'b1;
			end
		end
	end

	// ============================================================
	// gain: unsigned 16-bit word gives 1..65535, about 96.3 dB of span
	logic signed [W+GAIN_W:0] prod [2];

	always_comb
	begin
		for (int c = 0; c < 2; c++)
			prod[c] = hb_r[c] * $signed({1'b0, gain_i});
	end

	// wraps rather than saturates on gains above unity
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			out_i_o <= '0;
			out_q_o <= '0;
			out_vld_o <= 1'b0;
		end
		else if (ce_i)
		begin
			out_vld_o <= hb_vld_r;
			out_i_o <= gain_bypass_i ? hb_r[0] : prod[0][GAIN_SHIFT+W-1:GAIN_SHIFT];
			out_q_o <= gain_bypass_i ? hb_r[1] : prod[1][GAIN_SHIFT+W-1:GAIN_SHIFT];
		end
	end

	// ============================================================
	// checks
	chk_hb_two_out: assert property (@(posedge clock_i) disable iff (rst_i)
		(ce_i && in_vld_i && !hb_bypass_i) |=> (hb_vld_r && pend_r))
		else $error("halfband did not start a two-sample burst");
	chk_gain_pass: assert property (@(posedge clock_i) disable iff (rst_i)
		(ce_i && gain_bypass_i && hb_vld_r) |=> (out_i_o == $past(hb_r[0]) && out_vld_o))
		else $error("gain bypass did not pass the sample unchanged");
endmodule
`default_nettype wire

// ### sim/rxc_adc_model.sv
// behavioural model of the wideband converter feeding the channel
`timescale 1ns/1ps
`default_nettype none
module rxc_adc_model
	import rxc_pkg::*;
(
	// clock and mode
	input wire logic clock_i,
	input wire logic rnd_i,
	input wire logic signed [IN_W-1:0] level_i,
	// converter sample
	output logic signed [IN_W-1:0] data_o
);
	// ====
	// sampling
	integer seed = 73504;
	initial data_o = '0;
	// a new sample after every rising edge; random mode keeps data out of the rate checks
	always @(posedge clock_i)
		data_o <= rnd_i ? IN_W'($random(seed)) : level_i;
endmodule
`default_nettype wire

// ### sim/tb.sv
// self-checking bench for the receive channel
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rxc_pkg::*;
	// ====
	// stimulus and observation
	logic clock_i = 0, rst_i = 1, wr = 0, rd = 0, rd_d = 0, rnd = 0, ce = 1;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic [DATA_W-1:0] held = '0;
	logic signed [IN_W-1:0] lvl = 14'sd1000;
	wire logic signed [IN_W-1:0] adc;
	wire logic [DATA_W-1:0] rdata;
	wire logic signed [SMP_W-1:0] ai, aq, bi, bq;
	wire logic av, bv;
	logic [DATA_W-1:0] exp_q[$];
	int failures = 0, n_compared = 0, na = 0, nb = 0;
	always #2.5 clock_i = ~clock_i;
	rxc_adc_model i_rxc_adc_model (.clock_i(clock_i), .rnd_i(rnd), .level_i(lvl), .data_o(adc));
	rxc_channel i_rxc_channel (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce),
		.adc_data_i(adc), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .port_a_i_o(ai), .port_a_q_o(aq),
		.port_a_vld_o(av), .port_b_i_o(bi), .port_b_q_o(bq), .port_b_vld_o(bv));
	// ====
	// tasks
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
		n_compared++;
		if (seen !== want)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	// signals change only after an edge and stay put for a whole cycle
	task automatic bus(input logic w, input logic r, input logic [7:0] a,
		input logic [31:0] d);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge clock_i);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] want);
		exp_q.push_back(want);
		bus(0, 1, a, '0);
	endtask
	task automatic idle(input int n);
		bus(0, 0, '0, '0);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic wrap_up();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// read data count only in the cycle after the strobe; pulses counted per window
	always @(posedge clock_i)
	begin
		rd_d <= rd;
		if (rd_d)
			check(rdata, exp_q.pop_front());
		if (av)
			na++;
		if (bv)
			nb++;
	end
	// hang guard, far beyond the few thousand cycles the tests need
	initial
	begin
		#100us;
		failures++;
		wrap_up();
	end
	// ====
	// scenarios
	initial
	begin
		repeat (12) @(posedge clock_i);
		rst_i <= 0;
		@(posedge clock_i);
		// coefficient first: the fir starts summing a few cycles after reset
		bus(1, 0, 8'h00, 32'h000fffff);
		rreg(REG_OUT_CTRL, 32'hf);
		rreg(REG_GAIN_A, 32'h8000);
		rreg(8'hc0, '0);
		// a tuning word and its negative, two cycles each, leave the accumulator at zero
		bus(1, 0, REG_NCO_FREQ, 32'hdeadbeef);
		rreg(REG_NCO_FREQ, 32'hdeadbeef);
		bus(1, 0, REG_NCO_FREQ, 32'h21524111);
		rreg(REG_NCO_FREQ, 32'h21524111);
		bus(1, 0, REG_NCO_FREQ, '0);
		rreg(8'h00, 32'hffffffff);
		// decimation before length, so no long sum starts on unwritten coefficients
		bus(1, 0, REG_RCF_DEC, 32'hff);
		rreg(REG_RCF_DEC, 32'hff);
		bus(1, 0, REG_RCF_TAPS, 32'd200);
		rreg(REG_RCF_TAPS, 32'd159);
		idle(3);
		$display("test registers done");
		// unity path: one tap of half scale, gain a at one half, gain b bypassed
		bus(1, 0, 8'h00, 32'h40000);
		bus(1, 0, REG_RCF_TAPS, '0);
		bus(1, 0, REG_RCF_DEC, '0);
		bus(1, 0, REG_NCO_CTRL, 32'h1);
		bus(1, 0, REG_GAIN_A, 32'h4000);
		bus(1, 0, REG_OUT_CTRL, 32'hb);
		idle(300);
		// 1000 << 4 through unity combs, one tap of 2^18 over 2^19, then gain one half
		check(32'(bi), 32'd8000);
		check(32'(ai), 32'd4000);
		check({31'b0, bi == 0}, '0);
		check(32'(bq), '0);
		// translator on at zero tune: cosine only, then a quarter turn of offset
		bus(1, 0, REG_NCO_CTRL, '0);
		idle(300);
		check(32'(bq), '0);
		check({31'b0, bi > 0}, 32'h1);
		bus(1, 0, REG_NCO_PHASE, 32'h4000);
		idle(300);
		check({31'b0, bq < 0}, 32'h1);
		bus(1, 0, REG_NCO_CTRL, 32'h6);
		idle(300);
		check({31'b0, bq < 0}, 32'h1);
		$display("test translator and gain done");
		// integer rates: resampler 4, comb 2, fir 1 with 4 taps; halfband a on
		rnd <= 1;
		bus(1, 0, REG_RC2_DEC, 32'h3);
		bus(1, 0, REG_C5_DEC, 32'h1);
		// the extra taps need written coefficients before the length grows
		for (int k = 1; k < 4; k++)
			bus(1, 0, 8'(k), 32'h40000);
		bus(1, 0, REG_RCF_TAPS, 32'h3);
		bus(1, 0, REG_OUT_CTRL, 32'he);
		idle(200);
		// count between falling edges so no pulse races the window ends
		@(negedge clock_i);
		na = 0;
		nb = 0;
		repeat (800) @(negedge clock_i);
		check(32'(nb), 32'd100);
		check({31'b0, na inside {[199:201]}}, 32'h1);
		@(posedge clock_i);
		$display("test integer rates done");
		// non-integer resampling 3 over 4, comb 1, fir 3 gives one output in 4
		bus(1, 0, REG_RC2_INT, 32'h2);
		bus(1, 0, REG_C5_DEC, '0);
		bus(1, 0, REG_RCF_DEC, 32'h2);
		bus(1, 0, REG_RCF_TAPS, '0);
		idle(200);
		@(negedge clock_i);
		nb = 0;
		repeat (800) @(negedge clock_i);
		check({31'b0, nb inside {[199:201]}}, 32'h1);
		@(posedge clock_i);
		$display("test fractional rate done");
		// clock enable low: the port must hold while random samples keep arriving
		ce <= 1'b0;
		@(negedge clock_i);
		held = 32'({bv, bi});
		repeat (40) @(negedge clock_i);
		check(32'({bv, bi}), held);
		@(posedge clock_i);
		ce <= 1'b1;
		$display("test clock enable done");
		wrap_up();
	end
endmodule
`default_nettype wire
